/* File: shared/iemask_pkg.sv */
package iemask_pkg;

    // ****************************************************************
    // Register map: byte offsets on the APB bus, one word per register.
    // ****************************************************************
    localparam logic [7:0] IEMASK_OFS_EN_LOW   = 8'h00;
    localparam logic [7:0] IEMASK_OFS_EN_HIGH  = 8'h04;
    localparam logic [7:0] IEMASK_OFS_CRIT_LOW = 8'h08;
    localparam logic [7:0] IEMASK_OFS_CRIT_HIGH = 8'h0C;
    localparam logic [7:0] IEMASK_OFS_STATUS   = 8'h10;
    localparam logic [7:0] IEMASK_OFS_PENDING  = 8'h14;

    // ****************************************************************
    // Field layout.
    // ****************************************************************
    localparam int IEMASK_BIT_OS_SERVICE = 10;
    localparam int IEMASK_BIT_DATA_LOG   = 9;
    localparam int IEMASK_BIT_BUS_ERROR  = 8;
    localparam int IEMASK_NUM_SOURCES    = 25;

    // Writable bits of each register; the rest are reserved and read zero.
    localparam logic [15:0] IEMASK_HIGH_MASK = 16'h07FF;
    localparam logic [15:0] IEMASK_LOW_MASK  = 16'hFFFC;

    // Reset values.
    localparam logic [15:0] IEMASK_EN_RESET   = 16'h0000;
    localparam logic [15:0] IEMASK_CRIT_RESET = 16'h0000;

endpackage

/* File: verif/iemask_cpu_model.sv */
// ****************************************************************
// Interrupt sequencer stand-in: presents pending flags and halt state.
// ****************************************************************
module iemask_cpu_model
    import iemask_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        slow,
    input  wire logic [24:0] want_pend,
    input  wire logic        want_halt,
    output logic      [23:2] vector_pending,
    output logic             os_service_irq,
    output logic             data_log_irq,
    output logic             bus_error_irq,
    output logic             halted_rt
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [25:0] stage_q;
    logic [25:0] out_q;

    // Slow mode adds a stage, as a sequencer busy elsewhere would.
    always_ff @(posedge mclk) begin
        if (srst) begin
            stage_q <= 26'h0;
            out_q   <= 26'h0;
        end else begin
            stage_q <= {want_halt, want_pend};
            out_q   <= slow ? stage_q : {want_halt, want_pend};
        end
    end

    // Flags leave in snapshot order: os, data-log, vectors, bus error.
    assign os_service_irq = out_q[0];
    assign data_log_irq   = out_q[1];
    assign vector_pending = out_q[23:2];
    assign bus_error_irq  = out_q[24];
    assign halted_rt      = out_q[25];
endmodule

/* File: verif/interrupt_enable_and_debug_mask_test.sv */
module interrupt_enable_and_debug_mask_test
    import iemask_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    logic        mclk = 1'b0, srst = 1'b1, soft_reset = 1'b0, slow = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, acc_go = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [3:0]  pstrb = 4'hF;
    logic [31:0] pwdata = 32'h0, prdata, rng = 32'h11, b, r, r2;
    logic        pready, pslverr, os_irq, dl_irq, be_irq, halted_rt, want_halt = 1'b0;
    logic        os_acc, dl_acc, be_acc;
    logic [23:2] vec_pend, vec_acc;
    logic [24:0] want_pend = 25'h0, acc_last, acc_q[$];
    logic [15:0] m_el = 16'h0, m_eh = 16'h0, m_cl = 16'h0, m_ch = 16'h0;
    logic [31:0] rd_q[$];
    int          err_total = 0, n_compared = 0, cyc = 0;

    // ****************************************************************
    // Clock, partner and design.
    // ****************************************************************
    always #10 mclk = ~mclk;

    iemask_cpu_model cpu (.mclk(mclk), .srst(srst), .slow(slow), .want_pend(want_pend),
        .want_halt(want_halt), .vector_pending(vec_pend), .os_service_irq(os_irq),
        .data_log_irq(dl_irq), .bus_error_irq(be_irq), .halted_rt(halted_rt));

    iemask_top dut (.mclk(mclk), .srst(srst), .soft_reset(soft_reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .vector_pending(vec_pend),
        .os_service_irq(os_irq), .data_log_irq(dl_irq), .bus_error_irq(be_irq),
        .halted_rt(halted_rt), .vector_accept(vec_acc), .os_service_accept(os_acc),
        .data_log_accept(dl_acc), .bus_error_accept(be_acc));

    // ****************************************************************
    // Helpers.
    // ****************************************************************
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    // Register pair to source order: os, data-log, vectors 2..23, bus error.
    function automatic logic [24:0] emap(input logic [15:0] lo, input logic [15:0] hi);
        return {hi[8], hi[7:0], lo[15:2], hi[9], hi[10]};
    endfunction

    // One APB transfer; the master never assumes how soon pready comes.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic err);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        chk("pslverr", {31'h0, pslverr}, {31'h0, err});
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
        rd_q.push_back(exp);
        apb(1'b0, a, 32'h0, err);
    endtask

    task automatic readall();
        rd(IEMASK_OFS_EN_LOW, m_el, 1'b0);
        rd(IEMASK_OFS_EN_HIGH, m_eh, 1'b0);
        rd(IEMASK_OFS_CRIT_LOW, m_cl, 1'b0);
        rd(IEMASK_OFS_CRIT_HIGH, m_ch, 1'b0);
    endtask

    // Reserved bits are dropped from the model, as they must be in the device.
    task automatic setregs(input logic [15:0] el, eh, cl, ch);
        m_el = el & IEMASK_LOW_MASK;
        m_eh = eh & IEMASK_HIGH_MASK;
        m_cl = cl & IEMASK_LOW_MASK;
        m_ch = ch & IEMASK_HIGH_MASK;
        apb(1'b1, IEMASK_OFS_EN_LOW, {16'hFFFF, el}, 1'b0);
        apb(1'b1, IEMASK_OFS_EN_HIGH, {16'hFFFF, eh}, 1'b0);
        apb(1'b1, IEMASK_OFS_CRIT_LOW, {16'hFFFF, cl}, 1'b0);
        apb(1'b1, IEMASK_OFS_CRIT_HIGH, {16'hFFFF, ch}, 1'b0);
    endtask

    // Drives flags and halt, waits out the fixed latency, then notes the result.
    task automatic expect_acc(input logic [24:0] pend, input logic halt);
        logic [24:0] c;
        c = halt ? emap(m_cl, m_ch) : {25{1'b1}};
        want_pend <= pend;
        want_halt <= halt;
        repeat (5) @(posedge mclk);
        acc_last = pend & emap(m_el, m_eh) & c;
        acc_q.push_back(acc_last);
        acc_go <= 1'b1;
        @(posedge mclk);
        acc_go <= 1'b0;
    endtask

    // ****************************************************************
    // Output watcher and hang guard.
    // ****************************************************************
    always @(posedge mclk) begin
        cyc++;
        if (psel && penable && pready === 1'b1 && !pwrite)
            chk("prdata", prdata, rd_q.pop_front());
        if (acc_go)
            chk("accept", {7'h00, be_acc, vec_acc, dl_acc, os_acc},
                {7'h00, acc_q.pop_front()});
        if (cyc == 20000) begin
            err_total++;
            results();
        end
    end

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        readall();
        rd(8'h18, 16'h0000, 1'b1);
        apb(1'b1, 8'h1C, 32'hFFFFFFFF, 1'b1);
        setregs(16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF);
        readall();
        soft_reset <= 1'b1;
        @(posedge mclk);
        soft_reset <= 1'b0;
        readall();
        // Byte strobes: each write below touches one byte only.
        pstrb <= 4'h1;
        apb(1'b1, IEMASK_OFS_EN_LOW, 32'h0, 1'b0);
        pstrb <= 4'h2;
        apb(1'b1, IEMASK_OFS_CRIT_HIGH, 32'h0, 1'b0);
        pstrb <= 4'hF;
        m_el = m_el & 16'hFF00;
        m_ch = m_ch & 16'h00FF;
        readall();
        // Each source alone: plain, halted unmarked, halted marked, not pending.
        for (int i = 0; i < 25; i++) begin
            r = 32'h1 << i;
            b = {5'h00, r[0], r[1], r[24], r[23:16], r[15:2], 2'h0};
            setregs(b[15:0], b[31:16], 16'h0000, 16'h0000);
            expect_acc({25{1'b1}}, 1'b0);
            expect_acc({25{1'b1}}, 1'b1);
            setregs(b[15:0], b[31:16], b[15:0], b[31:16]);
            expect_acc({25{1'b1}}, 1'b1);
            expect_acc(~r[24:0], 1'b1);
        end
        // Random settings, slow partner and software reset levels mixed in.
        for (int k = 0; k < 40; k++) begin
            r = xs();
            r2 = xs();
            setregs(r[15:0], r[31:16], r2[15:0], r2[31:16]);
            r = xs();
            slow       <= r[26];
            soft_reset <= r[27];
            expect_acc(r[24:0], r[25]);
            rd(IEMASK_OFS_STATUS, {31'h0, r[25]}, 1'b0);
            rd(IEMASK_OFS_PENDING, {7'h00, acc_last}, 1'b0);
        end
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        m_el = 16'h0;
        m_eh = 16'h0;
        m_cl = 16'h0;
        m_ch = 16'h0;
        @(posedge mclk);
        readall();
        expect_acc({25{1'b1}}, 1'b0);
        results();
    end
endmodule

/* File: verilog/iemask_accept.sv */
// ********************************************************************
// Per-source accept stage: registers the qualified request vector.
// ********************************************************************
module iemask_accept
    import iemask_pkg::*;
(
    input  wire logic                          mclk,
    input  wire logic                          srst,
    input  wire logic [IEMASK_NUM_SOURCES-1:0] pending,
    input  wire logic [IEMASK_NUM_SOURCES-1:0] enable,
    input  wire logic [IEMASK_NUM_SOURCES-1:0] critical,
    input  wire logic                          halted_rt,
    output logic      [IEMASK_NUM_SOURCES-1:0] accept_q
);

    // Each source is gated alike, so a generate loop builds the slices.
    // The debug bit matters only while halted in real-time mode.
    genvar g;
    generate
        for (g = 0; g < IEMASK_NUM_SOURCES; g++) begin : g_src
            always_ff @(posedge mclk) begin
                if (srst) begin
                    accept_q[g] <= 1'b0;
                end else begin
                    accept_q[g] <= pending[g] & enable[g]
                                   & (~halted_rt | critical[g]);
                end
            end
        end
    endgenerate

endmodule

/* File: verilog/iemask_top.sv */
// Operation
// - High enable bit 10 gates the OS service interrupt.
// - High enable bit 9 gates the data-log interrupt.
// - High enable bit 8 gates the bus-error interrupt.
// - High enable bits 0 to 7 gate vectors 16 to 23.
// - Low enable bits 2 to 15 gate vectors 2 to 15.
// - Hardware reset clears both enable registers.
// - Software reset leaves both enable registers unchanged.
// - Debug enables matter only while halted in real-time mode.
// - Running in real-time mode ignores debug enables.
// - Halted: service needs both debug and normal enable set.
// - Debug enable registers are readable and writable.
// - Software reset leaves debug enable registers unchanged.
// - Hardware reset clears all debug enable bits.
// - High debug bit 10 marks OS service interrupt time-critical.
// - High debug bit 9 marks data-log interrupt time-critical.
// - High debug bit 8 marks bus-error interrupt time-critical.
// - Debug bits mark vectors 16-23 high and 2-15 low critical.
module iemask_top
    import iemask_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        soft_reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [23:2] vector_pending,
    input  wire logic        os_service_irq,
    input  wire logic        data_log_irq,
    input  wire logic        bus_error_irq,
    input  wire logic        halted_rt,
    output logic      [23:2] vector_accept,
    output logic             os_service_accept,
    output logic             data_log_accept,
    output logic             bus_error_accept
);

    // ****************************************************************
    // Register state.
    // ****************************************************************
    logic [15:0] irq_enable_low_q;
    logic [15:0] irq_enable_high_q;
    logic [15:0] halt_critical_enable_low_q;
    logic [15:0] halt_critical_enable_high_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic        halted_rt_q;

    logic        wr_en;
    logic        rd_en;
    logic [15:0] wdata16;
    logic [15:0] wmask16;

    logic [IEMASK_NUM_SOURCES-1:0] src_pending;
    logic [IEMASK_NUM_SOURCES-1:0] src_enable;
    logic [IEMASK_NUM_SOURCES-1:0] src_critical;
    logic [IEMASK_NUM_SOURCES-1:0] src_accept_q;

    // Decodes an offset into a mapped flag; used by both read and write.
    function automatic logic iemask_mapped(input logic [7:0] a);
        iemask_mapped = (a == IEMASK_OFS_EN_LOW)    || (a == IEMASK_OFS_EN_HIGH)   ||
                        (a == IEMASK_OFS_CRIT_LOW)  || (a == IEMASK_OFS_CRIT_HIGH) ||
                        (a == IEMASK_OFS_STATUS)    || (a == IEMASK_OFS_PENDING);
    endfunction

    // Merges a strobed write into a register, keeping only its writable bits.
    function automatic logic [15:0] iemask_merge(input logic [15:0] old,
                                                 input logic [15:0] wd,
                                                 input logic [15:0] bm,
                                                 input logic [15:0] keep);
        iemask_merge = ((old & ~bm) | (wd & bm)) & keep;
    endfunction

    // ****************************************************************
    // APB slave: zero wait states, read captured in setup, write in the access cycle.
    // ****************************************************************

    // The access phase completes in its first cycle; a write lands at the
    // edge that samples pready high, the same edge the master finishes on.
    assign wr_en   = psel & penable & pwrite & pready_q;
    assign rd_en   = psel & ~penable & ~pwrite;
    assign wdata16 = pwdata[15:0];
    assign wmask16 = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    // Ready and error answer one cycle after setup, during the access phase.
    always_ff @(posedge mclk) begin
        if (srst) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= psel & ~penable;
            pslverr_q <= psel & ~penable & ~iemask_mapped(paddr);
        end
    end

    // Normal enables: hardware reset clears them; soft_reset does not touch
    // them, so software keeps its setup across a software reset.
    always_ff @(posedge mclk) begin
        if (srst) begin
            irq_enable_low_q  <= IEMASK_EN_RESET;
            irq_enable_high_q <= IEMASK_EN_RESET;
        end else if (wr_en) begin
            if (paddr == IEMASK_OFS_EN_LOW) begin
                irq_enable_low_q <= iemask_merge(irq_enable_low_q, wdata16,
                                                 wmask16, IEMASK_LOW_MASK);
            end
            if (paddr == IEMASK_OFS_EN_HIGH) begin
                irq_enable_high_q <= iemask_merge(irq_enable_high_q, wdata16,
                                                  wmask16, IEMASK_HIGH_MASK);
            end
        end
    end

    // Debug enables: same reset behaviour, written 1 to mark, 0 to unmark.
    always_ff @(posedge mclk) begin
        if (srst) begin
            halt_critical_enable_low_q  <= IEMASK_CRIT_RESET;
            halt_critical_enable_high_q <= IEMASK_CRIT_RESET;
        end else if (wr_en) begin
            if (paddr == IEMASK_OFS_CRIT_LOW) begin
                halt_critical_enable_low_q <= iemask_merge(halt_critical_enable_low_q,
                                              wdata16, wmask16, IEMASK_LOW_MASK);
            end
            if (paddr == IEMASK_OFS_CRIT_HIGH) begin
                halt_critical_enable_high_q <= iemask_merge(halt_critical_enable_high_q,
                                               wdata16, wmask16, IEMASK_HIGH_MASK);
            end
        end
    end

    // Read data are captured in setup, so they stand through the access phase.
    always_ff @(posedge mclk) begin
        if (srst) begin
            prdata_q <= 32'h0000_0000;
        end else if (rd_en) begin
            unique case (paddr)
                IEMASK_OFS_EN_LOW:    prdata_q <= {16'h0000, irq_enable_low_q};
                IEMASK_OFS_EN_HIGH:   prdata_q <= {16'h0000, irq_enable_high_q};
                IEMASK_OFS_CRIT_LOW:  prdata_q <= {16'h0000, halt_critical_enable_low_q};
                IEMASK_OFS_CRIT_HIGH: prdata_q <= {16'h0000, halt_critical_enable_high_q};
                IEMASK_OFS_STATUS:    prdata_q <= {31'h0000_0000, halted_rt_q};
                IEMASK_OFS_PENDING:   prdata_q <= {7'h00, src_accept_q};
                default:              prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************************************
    // Source vectors: bit n of each vector is source n.
    // ****************************************************************

    // Sources 2 to 23 are vectors; 24 is bus error, 0 is OS service and
    // 1 is data log, reusing the two vector slots that do not exist.
    assign src_pending  = {bus_error_irq, vector_pending, data_log_irq, os_service_irq};
    assign src_enable   = {irq_enable_high_q[IEMASK_BIT_BUS_ERROR],
                           irq_enable_high_q[7:0],
                           irq_enable_low_q[15:2],
                           irq_enable_high_q[IEMASK_BIT_DATA_LOG],
                           irq_enable_high_q[IEMASK_BIT_OS_SERVICE]};
    assign src_critical = {halt_critical_enable_high_q[IEMASK_BIT_BUS_ERROR],
                           halt_critical_enable_high_q[7:0],
                           halt_critical_enable_low_q[15:2],
                           halt_critical_enable_high_q[IEMASK_BIT_DATA_LOG],
                           halt_critical_enable_high_q[IEMASK_BIT_OS_SERVICE]};

    // The halt flag comes from the debug logic on this clock, so no
    // synchroniser; the registered copy feeds only the status read, the accept stage takes it raw.
    always_ff @(posedge mclk) begin
        if (srst) begin
            halted_rt_q <= 1'b0;
        end else begin
            halted_rt_q <= halted_rt;
        end
    end

    // The accept stage applies debug bits only when halted.
    iemask_accept u_accept (
        .mclk      (mclk),
        .srst      (srst),
        .pending   (src_pending),
        .enable    (src_enable),
        .critical  (src_critical),
        .halted_rt (halted_rt),
        .accept_q  (src_accept_q)
    );

    // ****************************************************************
    // Outputs, each straight from a flop.
    // ****************************************************************
    assign prdata            = prdata_q;
    assign pready            = pready_q;
    assign pslverr           = pslverr_q;
    assign vector_accept     = src_accept_q[23:2];
    assign os_service_accept = src_accept_q[0];
    assign data_log_accept   = src_accept_q[1];
    assign bus_error_accept  = src_accept_q[24];

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    AST_OS_GATE: assert property (@(posedge mclk) disable iff (srst)
        !irq_enable_high_q[IEMASK_BIT_OS_SERVICE] |=> !os_service_accept)
        else $error("OS service accepted while disabled");
    AST_DLOG_GATE: assert property (@(posedge mclk) disable iff (srst)
        !irq_enable_high_q[IEMASK_BIT_DATA_LOG] |=> !data_log_accept)
        else $error("Data-log accepted while disabled");
    AST_BERR_GATE: assert property (@(posedge mclk) disable iff (srst)
        bus_error_irq && irq_enable_high_q[IEMASK_BIT_BUS_ERROR] && !halted_rt
        |=> bus_error_accept)
        else $error("Bus error not accepted while enabled and running");
    AST_HIGH_VEC: assert property (@(posedge mclk) disable iff (srst)
        vector_pending[16] && irq_enable_high_q[0] && !halted_rt |=> vector_accept[16])
        else $error("Vector 16 not accepted");
    AST_LOW_VEC: assert property (@(posedge mclk) disable iff (srst)
        !irq_enable_low_q[2] |=> !vector_accept[2])
        else $error("Vector 2 accepted while disabled");
    AST_RESET_CLEAR: assert property (@(posedge mclk)
        srst |=> irq_enable_low_q == 16'h0000 && halt_critical_enable_high_q == 16'h0000)
        else $error("Reset did not clear enables");
    AST_SOFT_KEEP: assert property (@(posedge mclk) disable iff (srst)
        soft_reset && !wr_en |=> $stable(irq_enable_high_q))
        else $error("Soft reset changed enables");
    AST_RUN_IGNORE: assert property (@(posedge mclk) disable iff (srst)
        !halted_rt && vector_pending[5] && irq_enable_low_q[5] |=> vector_accept[5])
        else $error("Running core used debug bit");
    AST_HALT_BLOCK: assert property (@(posedge mclk) disable iff (srst)
        halted_rt && !halt_critical_enable_low_q[5] |=> !vector_accept[5])
        else $error("Non-critical accepted while halted");
    AST_RESERVED: assert property (@(posedge mclk) disable iff (srst)
        ##1 (irq_enable_high_q[15:11] == 5'h00) && (halt_critical_enable_low_q[1:0] == 2'h0))
        else $error("Reserved bit set");

    // ****************************************************************
    // Assertions per source, per mode and per register access.
    // ****************************************************************

    // An enabled OS service request passes while the core runs.
    AST_OS_PASS: assert property (@(posedge mclk) disable iff (srst)
        os_service_irq && irq_enable_high_q[IEMASK_BIT_OS_SERVICE] && !halted_rt
        |=> os_service_accept)
        else $error("OS service request lost");

    // The data-log request passes on the same terms.
    AST_DLOG_PASS: assert property (@(posedge mclk) disable iff (srst)
        data_log_irq && irq_enable_high_q[IEMASK_BIT_DATA_LOG] && !halted_rt
        |=> data_log_accept)
        else $error("Data-log request lost");

    // A cleared bus-error enable blocks that source in every mode.
    AST_BERR_BLOCK: assert property (@(posedge mclk) disable iff (srst)
        !irq_enable_high_q[IEMASK_BIT_BUS_ERROR] |=> !bus_error_accept)
        else $error("Bus error accepted while disabled");

    // No upper vector passes without its enable bit.
    AST_HIGH_BLOCK: assert property (@(posedge mclk) disable iff (srst)
        1'b1 |=> (vector_accept[23:16] & ~$past(irq_enable_high_q[7:0])) == 8'h00)
        else $error("Upper vector accepted while disabled");

    // No lower vector passes without its enable bit.
    AST_LOW_BLOCK: assert property (@(posedge mclk) disable iff (srst)
        1'b1 |=> (vector_accept[15:2] & ~$past(irq_enable_low_q[15:2])) == 14'h0)
        else $error("Lower vector accepted while disabled");

    // Running, the upper vectors follow pending and enable alone.
    AST_HIGH_RUN: assert property (@(posedge mclk) disable iff (srst)
        !halted_rt
        |=> vector_accept[23:16] == $past(vector_pending[23:16] & irq_enable_high_q[7:0]))
        else $error("Upper vectors wrong while running");

    // Running, the lower vectors ignore the debug bits too.
    AST_LOW_RUN: assert property (@(posedge mclk) disable iff (srst)
        !halted_rt
        |=> vector_accept[15:2] == $past(vector_pending[15:2] & irq_enable_low_q[15:2]))
        else $error("Lower vectors wrong while running");

    // Halted, an upper vector needs its debug bit as well.
    AST_HALT_HIGH: assert property (@(posedge mclk) disable iff (srst)
        halted_rt |=> vector_accept[23:16] == $past(vector_pending[23:16]
            & irq_enable_high_q[7:0] & halt_critical_enable_high_q[7:0]))
        else $error("Upper vectors wrong while halted");

    // Halted, a lower vector needs its debug bit as well.
    AST_HALT_LOW: assert property (@(posedge mclk) disable iff (srst)
        halted_rt |=> vector_accept[15:2] == $past(vector_pending[15:2]
            & irq_enable_low_q[15:2] & halt_critical_enable_low_q[15:2]))
        else $error("Lower vectors wrong while halted");

    // Halted, an unmarked OS service request is held off.
    AST_HALT_OS: assert property (@(posedge mclk) disable iff (srst)
        halted_rt && !halt_critical_enable_high_q[IEMASK_BIT_OS_SERVICE]
        |=> !os_service_accept)
        else $error("Unmarked OS service accepted while halted");

    // Halted, an unmarked data-log request is held off.
    AST_HALT_DLOG: assert property (@(posedge mclk) disable iff (srst)
        halted_rt && !halt_critical_enable_high_q[IEMASK_BIT_DATA_LOG]
        |=> !data_log_accept)
        else $error("Unmarked data-log accepted while halted");

    // Halted, an unmarked bus error is held off.
    AST_HALT_BERR: assert property (@(posedge mclk) disable iff (srst)
        halted_rt && !halt_critical_enable_high_q[IEMASK_BIT_BUS_ERROR]
        |=> !bus_error_accept)
        else $error("Unmarked bus error accepted while halted");

    // Halted, a marked and enabled bus error still passes.
    AST_HALT_PASS: assert property (@(posedge mclk) disable iff (srst)
        halted_rt && bus_error_irq && irq_enable_high_q[IEMASK_BIT_BUS_ERROR]
        && halt_critical_enable_high_q[IEMASK_BIT_BUS_ERROR] |=> bus_error_accept)
        else $error("Marked bus error lost while halted");

    // Hardware reset clears the two registers the first reset check skips.
    AST_CRIT_RESET: assert property (@(posedge mclk)
        srst |=> halt_critical_enable_low_q == IEMASK_CRIT_RESET
        && irq_enable_high_q == IEMASK_EN_RESET)
        else $error("Reset did not clear debug enables");

    // A software reset leaves the other three registers alone too.
    AST_SOFT_KEEP_ALL: assert property (@(posedge mclk) disable iff (srst)
        soft_reset && !wr_en |=> $stable(halt_critical_enable_low_q)
        && $stable(halt_critical_enable_high_q) && $stable(irq_enable_low_q))
        else $error("Soft reset changed a register");

    // A full write to the low debug register lands at the access edge.
    AST_WRITE_LANDS: assert property (@(posedge mclk) disable iff (srst)
        wr_en && paddr == IEMASK_OFS_CRIT_LOW && pstrb[1:0] == 2'h3
        |=> halt_critical_enable_low_q == ($past(pwdata[15:0]) & IEMASK_LOW_MASK))
        else $error("Debug enable write lost");

    // The high debug register reads back during the access phase.
    AST_READ_CRIT: assert property (@(posedge mclk) disable iff (srst)
        psel && !penable && !pwrite && paddr == IEMASK_OFS_CRIT_HIGH
        |=> prdata == {16'h0000, $past(halt_critical_enable_high_q)})
        else $error("Debug enable read wrong");

    // An unmapped read answers zero and raises the error flag.
    AST_UNMAPPED: assert property (@(posedge mclk) disable iff (srst)
        psel && !penable && !pwrite && !iemask_mapped(paddr)
        |=> prdata == 32'h0000_0000 && pslverr)
        else $error("Unmapped read not refused");

endmodule
